// ---- include/rst_seq_pkg.sv ----
// Package: register map, field layout, timing constants and carriers for the reset sequencer
`default_nettype none
package rst_seq_pkg;
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;
	// Register offsets
	localparam logic [3:0]  OFF_PERIOD_SEL  = 4'h0;
	localparam logic [3:0]  OFF_CONFIG      = 4'h1;
	localparam logic [3:0]  OFF_FLAGS       = 4'h2;
	localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h3;
	localparam logic [3:0]  OFF_IRQ_MASK    = 4'h4;
	localparam logic [3:0]  OFF_RST_CAUSE   = 4'h5;
	// Period select field
	localparam int          PSEL_W          = 3;
	localparam logic [2:0]  PSEL_RESET      = 3'h7;
	localparam int          PERIOD_BASE_EXP = 8;
	localparam int          WDT_CNT_W       = 16;
	// Config fields
	localparam int          CFG_LVR_EN_BIT  = 0;
	localparam int          CFG_WDT_EN_BIT  = 1;
	localparam logic [1:0]  CFG_RESET       = 2'h0;
	// Flag bits
	localparam int          FLAG_TO_BIT     = 0;
	localparam int          FLAG_PD_BIT     = 1;
	// Interrupt / cause bits
	localparam int          EV_W            = 4;
	localparam int          EV_PIN          = 0;
	localparam int          EV_LVR          = 1;
	localparam int          EV_WDT_RUN      = 2;
	localparam int          EV_WDT_IDLE     = 3;
	// Port and program counter reset values
	localparam logic [7:0]  PORT_RESET      = 8'hff;
	localparam logic [7:0]  PC_RESET        = 8'h00;
	localparam int          NUM_PORTS       = 2;
	// Timing
	localparam longint      CLK_HZ          = 250000000;
	localparam longint      RESET_DELAY_MS  = 100;
	localparam longint      RESET_DELAY_CYC = (RESET_DELAY_MS * CLK_HZ + 999) / 1000;
	localparam longint      LVR_MIN_NS      = 1000;
	localparam longint      LVR_MIN_CYC     = (LVR_MIN_NS * CLK_HZ + 999999999) / 1000000000;
	localparam int          DLY_CNT_W       = 26;
	localparam int          LVR_CNT_W       = 12;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} reg_req_s;

	typedef struct packed {
		logic                  fullReset;
		logic                  pcSpReset;
		logic                  coreHold;
	} core_ctl_s;

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_DELAY,
		ST_RUN
	} seq_state_e;
endpackage
`default_nettype wire

// ---- hw/reset_and_wdt_period_control.sv ----
// Reset sequencer with watchdog period select, flags and event interrupt
`timescale 1ns/1ps
`default_nettype none
module reset_and_wdt_period_control #(
	parameter longint RESET_DELAY_CYCLES = rst_seq_pkg::RESET_DELAY_CYC
) (
	input  wire logic                               clock,
	input  wire logic                               resetn,
	input  wire logic                               externalResetPin_n,
	input  wire logic                               lowSupply,
	input  wire logic                               wdtTick,
	input  wire logic                               coreIdle,
	input  wire logic                               haltExec,
	input  wire logic                               clrWdt,
	input  wire logic [rst_seq_pkg::ADDR_W-1:0]     regAddr,
	input  wire logic [rst_seq_pkg::DATA_W-1:0]     regWdata,
	input  wire logic                               regWr,
	input  wire logic                               regRd,
	output logic      [rst_seq_pkg::DATA_W-1:0]     regRdata,
	output logic                                    coreHold,
	output logic                                    fullReset,
	output logic                                    pcSpReset,
	output logic      [7:0]                         programCounter,
	output logic      [rst_seq_pkg::NUM_PORTS*8-1:0] portData,
	output logic      [rst_seq_pkg::NUM_PORTS*8-1:0] portDir,
	output logic                                    timeoutFlag,
	output logic                                    powerdownFlag,
	output logic                                    irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic pinMeta_r, pinSync_r, lowMeta_r, lowSync_r;
	logic tickMeta_r, tickSync_r, tickPrev_r;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pinMeta_r  <= 1'b0;
			pinSync_r  <= 1'b0;
			lowMeta_r  <= 1'b0;
			lowSync_r  <= 1'b0;
			tickMeta_r <= 1'b0;
			tickSync_r <= 1'b0;
			tickPrev_r <= 1'b0;
		end else begin
			pinMeta_r  <= externalResetPin_n;
			pinSync_r  <= pinMeta_r;
			lowMeta_r  <= lowSupply;
			lowSync_r  <= lowMeta_r;
			tickMeta_r <= wdtTick;
			tickSync_r <= tickMeta_r;
			tickPrev_r <= tickSync_r;
		end
	end

	wire logic tickEdge = tickSync_r & ~tickPrev_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register file state

	logic [rst_seq_pkg::PSEL_W-1:0] periodSel_r;
	logic [1:0]                     config_r;
	logic [rst_seq_pkg::EV_W-1:0]   irqStatus_r, irqMask_r, rstCause_r;
	logic                           porPending_r;
	rst_seq_pkg::seq_state_e        state_r;

	wire logic selPeriod = (regAddr == rst_seq_pkg::OFF_PERIOD_SEL);
	wire logic selConfig = (regAddr == rst_seq_pkg::OFF_CONFIG);
	wire logic selStatus = (regAddr == rst_seq_pkg::OFF_IRQ_STATUS);
	wire logic selMask   = (regAddr == rst_seq_pkg::OFF_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog counter and period decode

	// Terminal count for a select code: 2^(8+code) ticks
	function automatic logic [rst_seq_pkg::WDT_CNT_W-1:0] wdtLimit(
		input logic [rst_seq_pkg::PSEL_W-1:0] code
	);
		logic [rst_seq_pkg::WDT_CNT_W:0] one;
		one = {{rst_seq_pkg::WDT_CNT_W{1'b0}}, 1'b1};
		wdtLimit = rst_seq_pkg::WDT_CNT_W'((one << (rst_seq_pkg::PERIOD_BASE_EXP + int'(code)))
			- 1'b1);
	endfunction

	logic [rst_seq_pkg::WDT_CNT_W-1:0] wdtCnt_r;
	wire logic wdtEnable  = config_r[rst_seq_pkg::CFG_WDT_EN_BIT];
	wire logic wdtTimeout = wdtEnable && tickEdge && (wdtCnt_r == wdtLimit(periodSel_r));
	wire logic wdtRun     = wdtTimeout && !coreIdle && (state_r == rst_seq_pkg::ST_RUN);
	wire logic wdtIdle    = wdtTimeout && coreIdle && (state_r == rst_seq_pkg::ST_RUN);

	////////////////////////////////////////////////////////////////////////////////
	// Low-supply qualification

	logic [rst_seq_pkg::LVR_CNT_W-1:0] lvrCnt_r;
	logic                              lvrEvent;
	wire logic lvrEnable = config_r[rst_seq_pkg::CFG_LVR_EN_BIT];
	localparam logic [rst_seq_pkg::LVR_CNT_W-1:0] LVR_LIMIT =
		rst_seq_pkg::LVR_CNT_W'(rst_seq_pkg::LVR_MIN_CYC);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lvrCnt_r <= '0;
		end else if (!lvrEnable || !lowSync_r) begin
			lvrCnt_r <= '0;
		end else if (lvrCnt_r != LVR_LIMIT) begin
			lvrCnt_r <= lvrCnt_r + 1'b1;
		end
	end

	// Fires once when the low lasts longer than the qualification time
	assign lvrEvent = lvrEnable && lowSync_r && (lvrCnt_r == LVR_LIMIT - 1'b1);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	wire logic pinEvent = !pinSync_r && (state_r == rst_seq_pkg::ST_RUN);
	wire logic hardReset = pinEvent || lvrEvent || wdtRun;
	logic [rst_seq_pkg::DLY_CNT_W-1:0] dlyCnt_r;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= rst_seq_pkg::ST_HOLD;
			dlyCnt_r <= '0;
		end else begin
			case (state_r)
				rst_seq_pkg::ST_HOLD: begin
					dlyCnt_r <= '0;
					if (pinSync_r && !(lvrEnable && lowSync_r)) begin
						state_r <= rst_seq_pkg::ST_DELAY;
					end
				end
				rst_seq_pkg::ST_DELAY: begin
					if (!pinSync_r) begin
						state_r <= rst_seq_pkg::ST_HOLD;
					end else if (64'(dlyCnt_r) >= RESET_DELAY_CYCLES - 1) begin
						state_r <= rst_seq_pkg::ST_RUN;
					end else begin
						dlyCnt_r <= dlyCnt_r + 1'b1;
					end
				end
				rst_seq_pkg::ST_RUN: begin
					if (hardReset) begin
						state_r <= rst_seq_pkg::ST_HOLD;
					end
				end
				default: begin
					state_r <= rst_seq_pkg::ST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wdtCnt_r <= '0;
		end else if (state_r != rst_seq_pkg::ST_RUN || clrWdt || haltExec || wdtTimeout) begin
			wdtCnt_r <= '0;
		end else if (wdtEnable && tickEdge) begin
			wdtCnt_r <= wdtCnt_r + 1'b1;
		end
	end

	assign coreHold  = (state_r != rst_seq_pkg::ST_RUN);
	assign fullReset = coreHold;
	assign pcSpReset = coreHold || wdtIdle;

	////////////////////////////////////////////////////////////////////////////////
	// Core-visible state: program counter, ports, flags

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			porPending_r <= 1'b1;
		end else if (state_r == rst_seq_pkg::ST_RUN) begin
			porPending_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			programCounter <= rst_seq_pkg::PC_RESET;
		end else if (pcSpReset || hardReset) begin
			programCounter <= rst_seq_pkg::PC_RESET;
		end else if (!coreIdle) begin
			programCounter <= programCounter + 1'b1;
		end
	end

	// Ports are only forced by power-on; a running reset keeps them
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			portData <= {rst_seq_pkg::NUM_PORTS{rst_seq_pkg::PORT_RESET}};
			portDir  <= {rst_seq_pkg::NUM_PORTS{rst_seq_pkg::PORT_RESET}};
		end else begin
			portData <= portData;
			portDir  <= portDir;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end else if (porPending_r) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end else if (wdtRun || wdtIdle) begin
			timeoutFlag   <= 1'b1;
		end else if (haltExec) begin
			powerdownFlag <= 1'b1;
		end else if (clrWdt) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and interrupt

	wire logic [rst_seq_pkg::EV_W-1:0] events = {wdtIdle, wdtRun, lvrEvent, pinEvent};

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			periodSel_r <= rst_seq_pkg::PSEL_RESET;
		end else if (hardReset) begin
			periodSel_r <= rst_seq_pkg::PSEL_RESET;
		end else if (regWr && selPeriod) begin
			periodSel_r <= regWdata[rst_seq_pkg::PSEL_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			config_r  <= rst_seq_pkg::CFG_RESET;
			irqMask_r <= '0;
		end else if (regWr) begin
			if (selConfig) begin
				config_r <= regWdata[1:0];
			end else if (selMask) begin
				irqMask_r <= regWdata[rst_seq_pkg::EV_W-1:0];
			end
		end
	end

	// Set beats clear so an event landing on a clear write is kept
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irqStatus_r <= '0;
			rstCause_r  <= '0;
		end else begin
			irqStatus_r <= (irqStatus_r & ~((regWr && selStatus) ?
				regWdata[rst_seq_pkg::EV_W-1:0] : '0)) | events;
			if (|events) begin
				rstCause_r <= events;
			end
		end
	end

	assign irq = |(irqStatus_r & irqMask_r);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			regRdata <= '0;
		end else if (!regRd) begin
			regRdata <= '0;
		end else if (selPeriod) begin
			regRdata <= {5'h00, periodSel_r};
		end else if (selConfig) begin
			regRdata <= {6'h00, config_r};
		end else if (regAddr == rst_seq_pkg::OFF_FLAGS) begin
			regRdata <= {6'h00, powerdownFlag, timeoutFlag};
		end else if (selStatus) begin
			regRdata <= {4'h0, irqStatus_r};
		end else if (selMask) begin
			regRdata <= {4'h0, irqMask_r};
		end else if (regAddr == rst_seq_pkg::OFF_RST_CAUSE) begin
			regRdata <= {4'h0, rstCause_r};
		end else begin
			regRdata <= '0;
		end
	end

endmodule
`default_nettype wire

// ---- dv/reset_seq_chk.sv ----
// Port-level assertion checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_seq_chk #(
	parameter longint RESET_DELAY_CYCLES = 16
) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        externalResetPin_n,
	input wire logic        lowSupply,
	input wire logic        regRd,
	input wire logic [3:0]  regAddr,
	input wire logic [7:0]  regRdata,
	input wire logic        coreHold,
	input wire logic        pcSpReset,
	input wire logic [7:0]  programCounter,
	input wire logic [15:0] portData,
	input wire logic [15:0] portDir,
	input wire logic        timeoutFlag,
	input wire logic        powerdownFlag
);
	int hiCnt;
	int lowCnt;
	// Saturating run lengths of pin high and supply low
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hiCnt <= 0;
			lowCnt <= 0;
		end else begin
			hiCnt <= !externalResetPin_n ? 0 : (hiCnt > 9999 ? hiCnt : hiCnt + 1);
			lowCnt <= !lowSupply ? 0 : (lowCnt > 9999 ? lowCnt : lowCnt + 1);
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	property p_delay; $fell(coreHold) |-> hiCnt >= RESET_DELAY_CYCLES; endproperty
	a_delay: assert property (p_delay) else $error("core released early");
	property p_pin; $fell(externalResetPin_n) && !coreHold |-> ##[1:4] coreHold; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_pc; coreHold && $past(coreHold) |-> programCounter == 8'h00; endproperty
	a_pc: assert property (p_pc) else $error("pc not cleared");
	property p_ports; portData == 16'hffff && portDir == 16'hffff; endproperty
	a_ports: assert property (p_ports) else $error("ports altered");
	property p_lvr; lowSupply && lowCnt < 200 && hiCnt > 8 && !coreHold |=> !coreHold; endproperty
	a_lvr: assert property (p_lvr) else $error("short low supply reset");
	property p_sel;
		$past(regRd) && $past(regAddr) == rst_seq_pkg::OFF_PERIOD_SEL |-> regRdata[7:3] == 5'h00;
	endproperty
	a_sel: assert property (p_sel) else $error("upper bits not zero");
	property p_idle;
		pcSpReset && !coreHold && !$past(coreHold) |=> !pcSpReset && programCounter == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("idle reset wrong");
	property p_flags;
		coreHold && $past(coreHold) && !externalResetPin_n |-> $stable({timeoutFlag, powerdownFlag});
	endproperty
	a_flags: assert property (p_flags) else $error("flags moved in pin reset");
	c_pin: cover property ($fell(externalResetPin_n) && !coreHold);
	c_idle: cover property (pcSpReset && !coreHold);
	c_lvr: cover property (lowCnt == 240);
endmodule
bind reset_and_wdt_period_control reset_seq_chk #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) chk (
	.clock              (clock),
	.resetn             (resetn),
	.externalResetPin_n (externalResetPin_n),
	.lowSupply          (lowSupply),
	.regRd              (regRd),
	.regAddr            (regAddr),
	.regRdata           (regRdata),
	.coreHold           (coreHold),
	.pcSpReset          (pcSpReset),
	.programCounter     (programCounter),
	.portData           (portData),
	.portDir            (portDir),
	.timeoutFlag        (timeoutFlag),
	.powerdownFlag      (powerdownFlag)
);
`default_nettype wire

// ---- dv/supply_pin_model.sv ----
// Reset switch, supply monitor and watchdog oscillator seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
	input  wire logic clock,
	input  wire logic press,
	input  wire logic lowReq,
	input  wire logic tickOn,
	output logic      externalResetPin_n,
	output logic      lowSupply,
	output logic      wdtTick
);
	logic [1:0] div = 2'h0;
	// Pull-up keeps the pin high whenever the switch is open
	assign externalResetPin_n = !press;
	assign lowSupply = lowReq;
	// Oscillator stands still while disabled, so no stray ticks
	always @(posedge clock) begin
		div <= tickOn ? div + 2'h1 : 2'h0;
	end
	assign wdtTick = div[1];
endmodule
`default_nettype wire

// ---- dv/reset_and_wdt_period_control_tb.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_wdt_period_control_tb;
	localparam longint DLY = 16;
	logic        clock, resetn, coreIdle, haltExec, clrWdt, regWr, regRd;
	logic        press, lowReq, tickOn, externalResetPin_n, lowSupply, wdtTick;
	logic        coreHold, fullReset, pcSpReset, timeoutFlag, powerdownFlag, irq;
	logic [3:0]  regAddr;
	logic [7:0]  regWdata, regRdata, programCounter;
	logic [15:0] portData, portDir;
	int          err_total = 0, tests_run = 0, cyc = 0;
	reset_and_wdt_period_control #(.RESET_DELAY_CYCLES(DLY)) dut (
		.clock              (clock),
		.resetn             (resetn),
		.externalResetPin_n (externalResetPin_n),
		.lowSupply          (lowSupply),
		.wdtTick            (wdtTick),
		.coreIdle           (coreIdle),
		.haltExec           (haltExec),
		.clrWdt             (clrWdt),
		.regAddr            (regAddr),
		.regWdata           (regWdata),
		.regWr              (regWr),
		.regRd              (regRd),
		.regRdata           (regRdata),
		.coreHold           (coreHold),
		.fullReset          (fullReset),
		.pcSpReset          (pcSpReset),
		.programCounter     (programCounter),
		.portData           (portData),
		.portDir            (portDir),
		.timeoutFlag        (timeoutFlag),
		.powerdownFlag      (powerdownFlag),
		.irq                (irq)
	);
	supply_pin_model partner (
		.clock              (clock),
		.press              (press),
		.lowReq             (lowReq),
		.tickOn             (tickOn),
		.externalResetPin_n (externalResetPin_n),
		.lowSupply          (lowSupply),
		.wdtTick            (wdtTick)
	);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Hang guard: the scenarios need about 2700 cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		cmp(16'(regRdata), 16'(e));
		@(posedge clock);
	endtask
	task automatic waitHold(input logic v, input int lim);
		int n;
		n = 0;
		while (coreHold !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
		cmp(16'(coreHold), 16'(v));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_por();
		cmp(portData, 16'hffff);
		cmp(portDir, 16'hffff);
		cmp(16'({timeoutFlag, powerdownFlag}), 16'h0000);
		cmp(16'(programCounter), 16'h0000);
		rd(rst_seq_pkg::OFF_PERIOD_SEL, 8'h07);
		waitHold(1'b0, 30);
		$display("power-on test ended");
	endtask
	task automatic t_regs();
		for (int c = 0; c < 8; c++) begin
			wr(rst_seq_pkg::OFF_PERIOD_SEL, 8'hf8 | 8'(c));
			rd(rst_seq_pkg::OFF_PERIOD_SEL, 8'(c));
		end
		wr(4'hf, 8'h5a);
		rd(4'hf, 8'h00);
		$display("register test ended");
	endtask
	task automatic t_pin();
		haltExec <= 1'b1;
		@(posedge clock);
		haltExec <= 1'b0;
		cycles(4);
		press <= 1'b1;
		waitHold(1'b1, 8);
		cmp(16'(fullReset), 16'h0001);
		cycles(1);
		cmp(16'(programCounter), 16'h0000);
		press <= 1'b0;
		waitHold(1'b0, 30);
		cmp(16'({timeoutFlag, powerdownFlag}), 16'h0001);
		rd(rst_seq_pkg::OFF_RST_CAUSE, 8'h01);
		cmp(16'(irq), 16'h0000);
		wr(rst_seq_pkg::OFF_IRQ_MASK, 8'h01);
		cmp(16'(irq), 16'h0001);
		wr(rst_seq_pkg::OFF_IRQ_STATUS, 8'h01);
		cmp(16'(irq), 16'h0000);
		$display("pin reset test ended");
	endtask
	task automatic t_lvr();
		wr(rst_seq_pkg::OFF_CONFIG, 8'h01);
		lowReq <= 1'b1;
		cycles(200);
		lowReq <= 1'b0;
		cycles(10);
		cmp(16'(coreHold), 16'h0000);
		lowReq <= 1'b1;
		waitHold(1'b1, 300);
		lowReq <= 1'b0;
		waitHold(1'b0, 30);
		cmp(16'({timeoutFlag, powerdownFlag}), 16'h0001);
		rd(rst_seq_pkg::OFF_RST_CAUSE, 8'h02);
		$display("low supply test ended");
	endtask
	task automatic t_wdt();
		int n;
		wr(rst_seq_pkg::OFF_CONFIG, 8'h02);
		wr(rst_seq_pkg::OFF_PERIOD_SEL, 8'h00);
		tickOn <= 1'b1;
		cycles(900);
		cmp(16'(coreHold), 16'h0000);
		waitHold(1'b1, 300);
		waitHold(1'b0, 30);
		cmp(16'({timeoutFlag, powerdownFlag}), 16'h0003);
		rd(rst_seq_pkg::OFF_PERIOD_SEL, 8'h07);
		rd(rst_seq_pkg::OFF_FLAGS, 8'h03);
		rd(rst_seq_pkg::OFF_RST_CAUSE, 8'h04);
		rd(rst_seq_pkg::OFF_CONFIG, 8'h02);
		clrWdt <= 1'b1;
		@(posedge clock);
		clrWdt <= 1'b0;
		haltExec <= 1'b1;
		coreIdle <= 1'b1;
		@(posedge clock);
		haltExec <= 1'b0;
		wr(rst_seq_pkg::OFF_PERIOD_SEL, 8'h00);
		n = 0;
		while (pcSpReset !== 1'b1 && n < 1400) begin
			@(posedge clock);
			n++;
		end
		cmp(16'(pcSpReset), 16'h0001);
		cycles(2);
		cmp(16'(coreHold), 16'h0000);
		cmp(16'(programCounter), 16'h0000);
		cmp(16'({timeoutFlag, powerdownFlag}), 16'h0003);
		rd(rst_seq_pkg::OFF_RST_CAUSE, 8'h08);
		coreIdle <= 1'b0;
		tickOn <= 1'b0;
		$display("watchdog test ended");
	endtask
	initial begin
		resetn = 1'b0;
		{coreIdle, haltExec, clrWdt, regWr, regRd, press, lowReq, tickOn} = 8'h00;
		regAddr = 4'h0;
		regWdata = 8'h00;
		cycles(5);
		resetn <= 1'b1;
		@(posedge clock);
		t_por();
		t_regs();
		t_pin();
		t_lvr();
		t_wdt();
		print_verdict();
	end
endmodule
`default_nettype wire
